// ---- core/nvmcc_pkg.sv ----
// Purpose: shared constants and types of the nvm command controller
// Assumes: apb with 32-bit data, one register per aligned word
// Notes:   register index times four gives the byte address
package nvmcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices and address width
  localparam logic [3:0] IDX_COMMAND_CONTROL      = 4'h0;
  localparam logic [3:0] IDX_SECTION_LOCK_CONTROL = 4'h1;
  localparam logic [3:0] IDX_OPERATION_STATUS     = 4'h2;
  localparam logic [3:0] IDX_INTERRUPT_ENABLE     = 4'h3;
  localparam logic [3:0] IDX_INTERRUPT_FLAGS      = 4'h4;
  localparam logic [3:0] IDX_FUSE_DATA_WORD       = 4'h6;
  localparam logic [3:0] IDX_TARGET_ADDRESS_WORD  = 4'h8;
  localparam int         ADDR_WIDTH               = 6;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int POS_APP_CODE_WRITE_PROTECT = 0;
  localparam int POS_BOOT_SECTION_LOCK      = 1;
  localparam int POS_FLASH_BUSY             = 0;
  localparam int POS_EEPROM_BUSY            = 1;
  localparam int POS_WRITE_ERROR            = 2;
  localparam int POS_EEPROM_READY           = 0;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and chosen constants
  localparam logic [15:0] RESET_WORD        = 16'h0000;
  localparam logic [15:0] EEPROM_REGION_HI  = 16'h1400;
  localparam logic [15:0] EEPROM_REGION_MSK = 16'hff00;
  localparam logic [15:0] SYSCFG_FUSE_ADDR  = 16'h0005;
  localparam int          POS_PRESERVE_FUSE = 0;

  ////////////////////////////////////////////////////////////////////////////
  // cycle counts of array operations, key window length in instructions
  localparam logic [11:0] CYC_PAGE_ERASE    = 12'h040;
  localparam logic [11:0] CYC_PAGE_WRITE    = 12'h040;
  localparam logic [11:0] CYC_BUFFER_CLEAR  = 12'h007;
  localparam logic [11:0] CYC_CHIP_ERASE    = 12'h100;
  localparam logic [11:0] CYC_EEPROM_ERASE  = 12'h080;
  localparam logic [11:0] CYC_FUSE_WRITE    = 12'h020;
  localparam logic [2:0]  KEY_WINDOW_INSNS  = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // commands and states
  typedef enum logic [2:0] {
    CMD_NONE               = 3'b000,
    CMD_PAGE_WRITE         = 3'b001,
    CMD_PAGE_ERASE         = 3'b010,
    CMD_ERASE_THEN_WRITE   = 3'b011,
    CMD_BUFFER_CLEAR       = 3'b100,
    CMD_FULL_CHIP_ERASE    = 3'b101,
    CMD_EEPROM_FULL_ERASE  = 3'b110,
    CMD_FUSE_PROGRAM       = 3'b111
  } nvmcc_cmd_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ERASE = 2'b01,
    ST_WRITE = 2'b10,
    ST_OTHER = 2'b11
  } nvmcc_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // array control carrier, each strobe bit but loadedOnly a level while the phase runs
  typedef struct packed {
    logic        flashErase;
    logic        flashWrite;
    logic        eepromErase;
    logic        eepromWrite;
    logic        loadedOnly;
    logic        chipFlash;
    logic        chipEeprom;
    logic        fuseWrite;
    logic [15:0] address;
    logic [15:0] data;
  } nvmcc_array_type;

  // page buffer load report from the store path
  typedef struct packed {
    logic        load;
    logic [15:0] address;
    logic        mixedSection;
    logic        protectedArea;
  } nvmcc_load_type;

endpackage : nvmcc_pkg

// ---- core/nvmcc_controller.sv ----
// Purpose: command execution of the nonvolatile memory controller
// Assumes: apb slave, one clock, synchronous active-high reset
// Notes:   array timing modelled by counters; page buffer lives outside
`timescale 1ns/100ps

module nvmcc_controller
  (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     reset,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [nvmcc_pkg::ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // cpu side
  input  wire logic                     spmKeyWritten,
  input  wire logic                     instructionDone,
  input  wire logic                     fromDebugPort,
  input  wire nvmcc_pkg::nvmcc_load_type bufferLoad,
  output logic                          cpuHalt,
  output logic                          interruptRequest,
  // fuse array
  input  wire logic [7:0]               systemConfigFuse,
  // sleep control
  input  wire logic                     sleepEnter,
  input  wire logic                     sleepIdleMode,
  input  wire logic                     wakeUp,
  output logic                          sleepReady,
  output logic                          clockRequest,
  output logic                          wakeRequest,
  // array and page buffer control
  output nvmcc_pkg::nvmcc_array_type    arrayControl,
  output logic                          bufferClear
  );
  import nvmcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  nvmcc_state_type state,         next_state;
  nvmcc_cmd_type   activeCmd,     next_activeCmd;
  logic [11:0]     count,         next_count;
  logic [2:0]      keyWindow,     next_keyWindow;
  logic [2:0]      commandReg,    next_commandReg;
  logic            appCodeWriteProtect, next_appCodeWriteProtect;
  logic            bootSectionLock,     next_bootSectionLock;
  logic            flashBusy,     next_flashBusy;
  logic            eepromBusy,    next_eepromBusy;
  logic            writeError,    next_writeError;
  logic            interruptSourceEnable, next_interruptSourceEnable;
  logic            eepromReady,   next_eepromReady;
  logic [15:0]     fuseDataWord,  next_fuseDataWord;
  logic [15:0]     targetAddressWord, next_targetAddressWord;
  logic            bufferLoaded,  next_bufferLoaded;
  logic            loadMixed,     next_loadMixed;
  logic            loadProtected, next_loadProtected;
  logic            eepromPreserveFuse, next_eepromPreserveFuse;
  logic            targetEeprom,  next_targetEeprom;
  logic [31:0]     next_prdata;
  logic            next_pready;
  logic            next_pslverr;
  logic            next_cpuHalt;
  logic            next_interruptRequest;
  logic            next_sleepReady;
  logic            next_clockRequest;
  logic            next_wakeRequest;
  nvmcc_array_type next_arrayControl;
  logic            next_bufferClear;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic inEeprom(input logic [15:0] address);
    inEeprom = (address & EEPROM_REGION_MSK) == EEPROM_REGION_HI;
  endfunction : inEeprom

  function automatic logic [3:0] regIndex(
    input logic [ADDR_WIDTH-1:0] address);
    regIndex = address[ADDR_WIDTH-1:2];
  endfunction : regIndex

  logic        accessDone;
  logic        writeHit;
  logic [3:0]  index;
  logic [15:0] wdata;
  logic        busy;
  logic        cmdWrite;
  logic        opEnd;

  assign accessDone = psel & penable & pready;
  assign writeHit   = accessDone & pwrite;
  assign index      = regIndex(paddr);
  assign wdata      = pwdata[15:0];
  assign busy       = flashBusy | eepromBusy;
  assign cmdWrite   = writeHit & (index == IDX_COMMAND_CONTROL);
  assign opEnd      = (state != ST_IDLE) && (count == 12'h001);

  ////////////////////////////////////////////////////////////////////////////
  // next values
  always_comb begin
    next_state                 = state;
    next_activeCmd             = activeCmd;
    next_count                 = count;
    next_keyWindow             = keyWindow;
    next_commandReg            = commandReg;
    next_appCodeWriteProtect   = appCodeWriteProtect;
    next_bootSectionLock       = bootSectionLock;
    next_flashBusy             = flashBusy;
    next_eepromBusy            = eepromBusy;
    next_writeError            = writeError;
    next_interruptSourceEnable = interruptSourceEnable;
    next_eepromReady           = eepromReady;
    next_fuseDataWord          = fuseDataWord;
    next_targetAddressWord     = targetAddressWord;
    next_bufferLoaded          = bufferLoaded;
    next_loadMixed             = loadMixed;
    next_loadProtected         = loadProtected;
    next_eepromPreserveFuse    = eepromPreserveFuse;
    next_targetEeprom          = targetEeprom;
    next_bufferClear           = 1'b0;

    if (spmKeyWritten) begin
      next_keyWindow = KEY_WINDOW_INSNS;
    end else if (instructionDone && keyWindow != 3'h0) begin
      next_keyWindow = keyWindow - 3'h1;
    end

    // store path marks the buffer and the last updated location
    if (bufferLoad.load) begin
      next_bufferLoaded      = 1'b1;
      next_targetAddressWord = bufferLoad.address;
      next_loadMixed         = loadMixed | bufferLoad.mixedSection;
      next_loadProtected     = loadProtected | bufferLoad.protectedArea;
    end

    // register writes
    if (writeHit) begin
      unique case (index)
        IDX_SECTION_LOCK_CONTROL: begin
          next_appCodeWriteProtect = appCodeWriteProtect
                                   | wdata[POS_APP_CODE_WRITE_PROTECT];
          next_bootSectionLock     = bootSectionLock
                                   | wdata[POS_BOOT_SECTION_LOCK];
        end
        IDX_INTERRUPT_ENABLE:
          next_interruptSourceEnable = wdata[POS_EEPROM_READY];
        IDX_FUSE_DATA_WORD:      next_fuseDataWord      = wdata;
        IDX_TARGET_ADDRESS_WORD: next_targetAddressWord = wdata;
        default: ;
      endcase
    end

    // operation sequencing
    unique case (state)
      ST_IDLE: begin
        if (cmdWrite && keyWindow != 3'h0 && !busy) begin
          next_commandReg   = wdata[2:0];
          next_targetEeprom = inEeprom(targetAddressWord);
          next_activeCmd    = nvmcc_cmd_type'(wdata[2:0]);
          next_writeError   = 1'b0;
          unique case (nvmcc_cmd_type'(wdata[2:0]))
            CMD_NONE: ;
            CMD_PAGE_WRITE, CMD_PAGE_ERASE, CMD_ERASE_THEN_WRITE: begin
              if (loadProtected || loadMixed) begin
                next_writeError = 1'b1;
              end else if (wdata[2:0] == CMD_PAGE_WRITE
                           || bufferLoaded) begin
                next_flashBusy  = !inEeprom(targetAddressWord);
                next_eepromBusy = inEeprom(targetAddressWord);
                if (wdata[2:0] == CMD_PAGE_WRITE) begin
                  next_state = ST_WRITE;
                  next_count = CYC_PAGE_WRITE;
                end else begin
                  next_state = ST_ERASE;
                  next_count = CYC_PAGE_ERASE;
                end
              end
            end
            CMD_BUFFER_CLEAR: begin
              next_state = ST_OTHER;
              next_count = CYC_BUFFER_CLEAR;
            end
            CMD_FULL_CHIP_ERASE: begin
              next_state      = ST_OTHER;
              next_count      = CYC_CHIP_ERASE;
              next_flashBusy  = 1'b1;
              next_eepromBusy = !eepromPreserveFuse;
            end
            CMD_EEPROM_FULL_ERASE: begin
              next_state      = ST_OTHER;
              next_count      = CYC_EEPROM_ERASE;
              next_eepromBusy = 1'b1;
            end
            CMD_FUSE_PROGRAM: begin
              if (fromDebugPort) begin
                next_state     = ST_OTHER;
                next_count     = CYC_FUSE_WRITE;
                next_flashBusy = 1'b1;
              end
            end
          endcase
        end
      end
      ST_ERASE: begin
        next_count = count - 12'h001;
        if (opEnd) begin
          if (activeCmd == CMD_ERASE_THEN_WRITE) begin
            next_state = ST_WRITE;
            next_count = CYC_PAGE_WRITE;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_WRITE, ST_OTHER: begin
        next_count = count - 12'h001;
        if (opEnd) begin
          next_state = ST_IDLE;
        end
      end
    endcase

    if (opEnd && next_state == ST_IDLE) begin
      next_flashBusy  = 1'b0;
      next_eepromBusy = 1'b0;
      next_commandReg = CMD_NONE;
      // clear buffer after page write, page erase or buffer clear, not after full erases or fuse program
      if (activeCmd != CMD_FULL_CHIP_ERASE
          && activeCmd != CMD_EEPROM_FULL_ERASE
          && activeCmd != CMD_FUSE_PROGRAM) begin
        next_bufferClear = 1'b1;
      end
    end

    if (wakeUp) begin
      next_bufferClear = 1'b1;
    end
    if (next_bufferClear) begin
      next_bufferLoaded  = bufferLoad.load;
      next_loadMixed     = bufferLoad.load & bufferLoad.mixedSection;
      next_loadProtected = bufferLoad.load & bufferLoad.protectedArea;
    end

    // ready set while eeprom not busy, set beats clear
    if (writeHit && index == IDX_INTERRUPT_FLAGS
        && wdata[POS_EEPROM_READY]) begin
      next_eepromReady = 1'b0;
    end
    if (!eepromBusy) begin
      next_eepromReady = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer and outputs
  always_comb begin
    next_pready  = psel & penable & !pready;
    next_pslverr = 1'b0;
    next_prdata  = 32'h00000000;
    if (psel && penable && !pready) begin
      unique case (index)
        IDX_COMMAND_CONTROL:      next_prdata[2:0] = commandReg;
        IDX_SECTION_LOCK_CONTROL: begin
          next_prdata[POS_APP_CODE_WRITE_PROTECT] = appCodeWriteProtect;
          next_prdata[POS_BOOT_SECTION_LOCK]      = bootSectionLock;
        end
        IDX_OPERATION_STATUS: begin
          next_prdata[POS_FLASH_BUSY]  = flashBusy;
          next_prdata[POS_EEPROM_BUSY] = eepromBusy;
          next_prdata[POS_WRITE_ERROR] = writeError;
        end
        IDX_INTERRUPT_ENABLE:
          next_prdata[POS_EEPROM_READY] = interruptSourceEnable;
        IDX_INTERRUPT_FLAGS:
          next_prdata[POS_EEPROM_READY] = eepromReady;
        IDX_FUSE_DATA_WORD:      next_prdata[15:0] = fuseDataWord;
        IDX_TARGET_ADDRESS_WORD: next_prdata[15:0] = targetAddressWord;
        default:                 next_pslverr = 1'b1;
      endcase
    end

    // halt for flash work, buffer clear, full erases
    next_cpuHalt = (next_state != ST_IDLE)
                 && (next_flashBusy
                     || next_activeCmd == CMD_BUFFER_CLEAR
                     || next_activeCmd == CMD_EEPROM_FULL_ERASE);

    next_interruptRequest = interruptSourceEnable & next_eepromReady;
    next_wakeRequest = next_interruptRequest & sleepEnter & sleepIdleMode;
    // hold clock for any running operation
    next_clockRequest = next_state != ST_IDLE;
    next_sleepReady   = sleepEnter & (next_state == ST_IDLE);

    next_arrayControl             = '0;
    next_arrayControl.address     = next_targetAddressWord;
    next_arrayControl.data        = next_fuseDataWord;
    next_arrayControl.loadedOnly  = next_targetEeprom;
    if (next_state == ST_WRITE) begin
      next_arrayControl.flashWrite  = !next_targetEeprom;
      next_arrayControl.eepromWrite = next_targetEeprom;
    end
    if (next_state == ST_ERASE) begin
      next_arrayControl.flashErase  = !next_targetEeprom;
      next_arrayControl.eepromErase = next_targetEeprom;
    end
    if (next_state == ST_OTHER) begin
      next_arrayControl.chipFlash  = next_activeCmd == CMD_FULL_CHIP_ERASE;
      next_arrayControl.chipEeprom = next_eepromBusy
        && (next_activeCmd == CMD_FULL_CHIP_ERASE
            || next_activeCmd == CMD_EEPROM_FULL_ERASE);
      next_arrayControl.fuseWrite  = next_activeCmd == CMD_FUSE_PROGRAM;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clock) begin
    if (reset) begin
      state                 <= ST_IDLE;
      activeCmd             <= CMD_NONE;
      count                 <= 12'h000;
      keyWindow             <= 3'h0;
      commandReg            <= CMD_NONE;
      appCodeWriteProtect   <= 1'b0;
      bootSectionLock       <= 1'b0;
      flashBusy             <= 1'b0;
      eepromBusy            <= 1'b0;
      writeError            <= 1'b0;
      interruptSourceEnable <= 1'b0;
      eepromReady           <= 1'b0;
      fuseDataWord          <= RESET_WORD;
      targetAddressWord     <= RESET_WORD;
      bufferLoaded          <= 1'b0;
      loadMixed             <= 1'b0;
      loadProtected         <= 1'b0;
      eepromPreserveFuse    <= systemConfigFuse[POS_PRESERVE_FUSE];
      targetEeprom          <= 1'b0;
      prdata                <= 32'h00000000;
      pready                <= 1'b0;
      pslverr               <= 1'b0;
      cpuHalt               <= 1'b0;
      interruptRequest      <= 1'b0;
      sleepReady            <= 1'b0;
      clockRequest          <= 1'b0;
      wakeRequest           <= 1'b0;
      arrayControl          <= '0;
      bufferClear           <= 1'b1;
    end else begin
      state                 <= next_state;
      activeCmd             <= next_activeCmd;
      count                 <= next_count;
      keyWindow             <= next_keyWindow;
      commandReg            <= next_commandReg;
      appCodeWriteProtect   <= next_appCodeWriteProtect;
      bootSectionLock       <= next_bootSectionLock;
      flashBusy             <= next_flashBusy;
      eepromBusy            <= next_eepromBusy;
      writeError            <= next_writeError;
      interruptSourceEnable <= next_interruptSourceEnable;
      eepromReady           <= next_eepromReady;
      fuseDataWord          <= next_fuseDataWord;
      targetAddressWord     <= next_targetAddressWord;
      bufferLoaded          <= next_bufferLoaded;
      loadMixed             <= next_loadMixed;
      loadProtected         <= next_loadProtected;
      eepromPreserveFuse    <= next_eepromPreserveFuse;
      targetEeprom          <= next_targetEeprom;
      prdata                <= next_prdata;
      pready                <= next_pready;
      pslverr               <= next_pslverr;
      cpuHalt               <= next_cpuHalt;
      interruptRequest      <= next_interruptRequest;
      sleepReady            <= next_sleepReady;
      clockRequest          <= next_clockRequest;
      wakeRequest           <= next_wakeRequest;
      arrayControl          <= next_arrayControl;
      bufferClear           <= next_bufferClear;
    end
  end

endmodule : nvmcc_controller

// ---- verif/nvmcc_controller_asserts.sv ----
// Purpose: port checks of nvmcc_controller
// Assumes: sync active-high reset
// Notes:   bound to every instance
`timescale 1ns/100ps
module nvmcc_controller_asserts
  import nvmcc_pkg::*;
  (input wire logic clock, reset, psel, penable, pready, pslverr,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire logic cpuHalt, bufferClear, clockRequest, sleepReady,
   input wire logic sleepIdleMode, wakeRequest, wakeUp,
   input wire nvmcc_array_type arrayControl);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_one_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("late ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready");
  a_unmapped_err: assert property (pready |->
    pslverr == !(paddr[5:2] inside {0, 1, 2, 3, 4, 6, 8})) else $error("err");
  a_flash_halt: assert property (
    arrayControl.flashWrite || arrayControl.flashErase |-> cpuHalt)
    else $error("flash op without halt");
  a_eeprom_runs: assert property (arrayControl.eepromWrite ||
    arrayControl.eepromErase && arrayControl.loadedOnly |-> !cpuHalt)
    else $error("eeprom op halts");
  a_clear_seven: assert property ($rose(cpuHalt) &&
    !(|arrayControl[39:32]) |-> cpuHalt[*7] ##1 (!cpuHalt && bufferClear))
    else $error("buffer clear timing");
  a_write_clear: assert property (
    $fell(arrayControl.flashWrite || arrayControl.eepromWrite)
    |-> ##[0:1] bufferClear) else $error("no clear after write");
  a_erase_keep: assert property (
    $fell(arrayControl.flashErase || arrayControl.eepromErase)
    && (arrayControl.flashWrite || arrayControl.eepromWrite) |-> !bufferClear)
    else $error("buffer cleared between phases");
  a_sleep_hold: assert property (sleepReady |-> !clockRequest)
    else $error("sleep during op");
  a_idle_wake: assert property (wakeRequest |-> $past(sleepIdleMode))
    else $error("wake from deep sleep");
  a_wake_clear: assert property (wakeUp |-> ##[1:2] bufferClear)
    else $error("no clear on wake");
  cover property (bufferClear);
  cover property (arrayControl.eepromWrite);
  cover property (wakeRequest);
endmodule : nvmcc_controller_asserts
bind nvmcc_controller nvmcc_controller_asserts nvmcc_controller_asserts_i (.*);

// ---- verif/nvmcc_cpu_model.sv ----
// Purpose: cpu side of the controller: key, instructions, buffer stores
// Assumes: driven just after rising edges
// Notes:   released address shows the inverse
`timescale 1ns/100ps
module nvmcc_cpu_model
  import nvmcc_pkg::*;
  (input  wire logic     clock,
   output logic          spmKeyWritten, instructionDone,
   output nvmcc_load_type bufferLoad);
  initial begin
    spmKeyWritten = 1'b0;
    instructionDone = 1'b0;
    bufferLoad = '0;
  end
  task automatic key(input int insns);
    @(posedge clock) spmKeyWritten <= 1'b1;
    @(posedge clock) spmKeyWritten <= 1'b0;
    repeat (insns) begin
      instructionDone <= 1'b1;
      @(posedge clock);
    end
    instructionDone <= 1'b0;
  endtask : key
  task automatic load(input logic [15:0] a, input logic prot);
    @(posedge clock) bufferLoad <= '{1'b1, a, 1'b0, prot};
    @(posedge clock) bufferLoad <= '{1'b0, ~a, 1'b0, 1'b0};
  endtask : load
endmodule : nvmcc_cpu_model

// ---- verif/nvmcc_controller_test.sv ----
// Purpose: register-level test of nvmcc_controller
// Assumes: apb master with one request at a time
// Notes:   preserve fuse held set
`timescale 1ns/100ps
module nvmcc_controller_test;
  import nvmcc_pkg::*;
  logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, perr;
  logic fromDebugPort = 0, sleepEnter = 0, sleepIdleMode = 0, wakeUp = 0;
  logic [5:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [7:0] systemConfigFuse = 8'h01;
  logic pready, pslverr, spmKeyWritten, instructionDone, cpuHalt, bufferClear;
  logic interruptRequest, sleepReady, clockRequest, wakeRequest;
  nvmcc_load_type bufferLoad;
  nvmcc_array_type arrayControl;
  int err_total = 0, total_checks = 0;
  always #25 clock = ~clock;
  nvmcc_cpu_model cpu (.clock, .spmKeyWritten, .instructionDone, .bufferLoad);
  nvmcc_controller nvmcc_controller_i (.*);
  task automatic check(input string n, input logic [39:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clock) penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    {rd, perr} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic cmd(input logic [2:0] c, input int insns);
    cpu.key(insns);
    apb(1, 6'h00, {29'h0, c});
  endtask : cmd
  task automatic idle;
    do apb(0, 6'h08, 0); while (rd[1:0] !== 2'b00);
  endtask : idle
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #1000000;
    err_total++;
    tally_and_finish;
  end
  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    apb(0, 6'h10, 0);
    check("ready flag", rd, 1);
    apb(0, 6'h14, 0);
    check("unmapped", {perr, rd[30:0]}, 32'h80000000);
    apb(1, 6'h00, 4);
    cmd(4, 4);
    apb(0, 6'h00, 0);
    check("unkeyed cmd", rd, 0);
    cmd(4, 3);
    @(negedge clock) check("clear halt", cpuHalt, 1);
    idle;
    cmd(2, 0);
    apb(0, 6'h08, 0);
    check("empty erase", rd, 0);
    cpu.load(16'h1410, 0);
    cmd(3, 0);
    @(negedge clock) check("eeprom run", {cpuHalt, clockRequest}, 1);
    apb(1, 6'h10, 1);
    apb(1, 6'h0c, 1);
    @(posedge clock);
    @(negedge clock) check("flag cleared", interruptRequest, 0);
    cmd(4, 0);
    sleepEnter <= 1'b1;
    apb(0, 6'h00, 0);
    check("busy cmd", rd, 3);
    @(negedge clock) check("sleep", {sleepReady, clockRequest}, 1);
    idle;
    repeat (3) @(posedge clock);
    @(negedge clock) check("irq", {interruptRequest, sleepReady}, 3);
    @(posedge clock) sleepIdleMode <= 1'b1;
    repeat (2) @(negedge clock);
    check("idle wake", wakeRequest, 1);
    @(posedge clock) sleepIdleMode <= 1'b0;
    repeat (2) @(negedge clock);
    check("deep wake", wakeRequest, 0);
    @(posedge clock) wakeUp <= 1'b1;
    @(posedge clock) {wakeUp, sleepEnter} <= 2'b00;
    apb(1, 6'h0c, 0);
    @(posedge clock);
    @(negedge clock) check("masked", interruptRequest, 0);
    cpu.load(16'h0200, 0);
    cmd(1, 0);
    @(negedge clock);
    check("flash write", {cpuHalt, arrayControl.flashWrite}, 3);
    idle;
    cpu.load(16'h0200, 1);
    cmd(1, 0);
    apb(0, 6'h08, 0);
    check("protected", rd, 4);
    apb(1, 6'h04, 3);
    cmd(5, 0);
    @(negedge clock) check("chip", arrayControl[34:33], 2);
    idle;
    apb(1, 6'h20, 5);
    apb(1, 6'h18, 16'h00a5);
    cmd(7, 0);
    apb(0, 6'h08, 0);
    check("cpu fuse", rd, 0);
    fromDebugPort <= 1'b1;
    cmd(7, 0);
    @(negedge clock) check("fuse", arrayControl[32:0], 33'h1000500a5);
    idle;
    cmd(6, 0);
    @(negedge clock) check("ee erase", cpuHalt, 1);
    @(posedge clock) reset <= 1'b1;
    @(posedge clock) reset <= 1'b0;
    @(negedge clock) check("abort", {cpuHalt, clockRequest}, 0);
    apb(0, 6'h08, 0);
    check("abort busy", rd, 0);
    tally_and_finish;
  end
endmodule : nvmcc_controller_test
